// *** pkg/fabric_consts.svh ***
// Function
// R1: non-host, non-boot agents reset base ID to 0xFF
// R2: host resets permission/found bits set; agents cleared
// R3: hop zero maintenance read answered to arrival port
// R4: port info register gives port count, arrival port
// R5: nonzero hop decremented, forwarded via routing table
// R6: responses routed by destination through routing table
// R7: routing entries writable by hop-zero maintenance writes
// R8: boot device keeps ID 0xFE, reached by hops
// R9: host sets found flag, assigns unique IDs
// R10: permission bit set after exploration; gates issuing
// R11: host lock at 0x68, component tag at 0x6C
// R12: 8-bit port and 8-bit device IDs
// R13: recover corrupt packet; retry and throttle flow control
// R14: ordering kept at flow level one
// R15: switch keeps error check intact internally
// R16: switch carries packets up to 276 bytes
// R17: end points carry payloads up to 256 bytes
// R18: seven identity and operation capability registers present
// R19: maintenance target; switch selected by hop count
// R20: simple target: 34-bit address, writes and reads
// R21: simple master originates maintenance, write, read requests
// R22: complex master adds atomic set, port-write, mailbox
// R23: maintenance responses leave on request's arrival port
// R24: no permission bit means respond only, never issue
// R25: identical decode on every input port
`ifndef FABRIC_CONSTS_SVH
`define FABRIC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets in the control and status space
// ----------------------------------------------------------------
`define OFF_DEV_IDENT 24'h000000
`define OFF_DEV_INFO 24'h000004
`define OFF_ASM_IDENT 24'h000008
`define OFF_ASM_INFO 24'h00000c
`define OFF_PE_FEAT 24'h000010
`define OFF_PORT_INFO 24'h000014
`define OFF_SRC_OPS 24'h000018
`define OFF_DST_OPS 24'h00001c
`define OFF_BASE_ID 24'h000060
`define OFF_HOST_LOCK 24'h000068
`define OFF_COMP_TAG 24'h00006c
`define OFF_ROUTE_SEL 24'h000070
`define OFF_ROUTE_PORT 24'h000074
`define OFF_PORT_CTL 24'h00013c

// ----------------------------------------------------------------
// identifiers, hop counts, sizes, reset values
// ----------------------------------------------------------------
`define ID_UNASSIGNED 8'hff
`define ID_BOOT 8'hfe
`define ID_HOST 8'h00
`define HOP_FINAL 8'h00
`define HOP_STEP 8'h01
`define HOP_RESP 8'hff
`define MAX_SWITCH_PKT 9'h114
`define MAX_PAYLOAD 9'h100
`define CTL_MASTER_EN 31
`define CTL_DISCOVERED 29
`define LOCK_RESET 32'h0000ffff
`define TAG_RESET 32'h00000000
`define READ_NONE 32'h00000000

`endif

// *** pkg/fabric_pkg.sv ***
// ----------------------------------------------------------------
// packet types shared by the switch core and the testbench
// ----------------------------------------------------------------
package fabric_pkg;

    // coarse class of a packet as decoded by the port logic
    typedef enum logic [1:0] {
        PK_MREAD,
        PK_MWRITE,
        PK_MRESP,
        PK_OTHER
    } pkt_kind_t;

    // one packet header plus its single data word and check field
    typedef struct packed {
        pkt_kind_t kind;
        logic [7:0] hop;
        logic [7:0] destId;
        logic [7:0] srcId;
        logic [1:0] port;
        logic [23:0] offset;
        logic [31:0] data;
        logic [8:0] lenBytes;
        logic [15:0] crc;
        logic corrupt;
    } pkt_t;

endpackage

// *** core/fabric_discovery_maintenance.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fabric_consts.svh"

// ----------------------------------------------------------------
// ingress queue: in-order, with honest full and empty
// ----------------------------------------------------------------
module pkt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    // pointer width; wrap is explicit
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
    logic [AW-1:0] wrPtr_q; // next slot to fill
    logic [AW-1:0] rdPtr_q; // oldest slot
    logic [AW:0] count_q; // occupancy
    logic push; // accepted write
    logic pop; // accepted read

    // handshakes from occupancy
    assign inReady = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);

    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // oldest word sits on the read port
    assign outData = mem[rdPtr_q];

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end

            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            // push with pop: count unchanged
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------
// maintenance target and id-routed switch core
// ----------------------------------------------------------------
module fabric_discovery_maintenance
    import fabric_pkg::*;
#(
    parameter int PORTS = 4,
    parameter int FIFO_DEPTH = 8,
    parameter bit IS_HOST = 1'b0,
    parameter bit IS_BOOT = 1'b0,
    parameter bit IS_SWITCH = 1'b1,
    parameter logic [1:0] DEFAULT_PORT = 2'h0,
    parameter logic [1:0] BOOT_PORT = 2'h1,
    parameter logic [1:0] HOST_PORT = 2'h2,
    // identity codes: values are arbitrary
    parameter logic [31:0] DEV_IDENT = 32'h1234_5678,
    parameter logic [31:0] DEV_INFO = 32'h0000_0001,
    parameter logic [31:0] ASM_IDENT = 32'h0000_abcd,
    parameter logic [31:0] ASM_INFO = 32'h0000_0100,
    parameter logic [31:0] PE_FEAT = 32'h1000_0001,
    parameter logic [31:0] SRC_OPS = 32'h0000_0000,
    parameter logic [31:0] DST_OPS = 32'h0000_00c0
) (
    input wire logic clk,
    input wire logic rst,
    input wire fabric_pkg::pkt_t inPkt,
    input wire logic inValid,
    output logic inReady,
    output fabric_pkg::pkt_t outPkt,
    output logic outValid,
    input wire logic outReady,
    output logic [7:0] baseDeviceId,
    output logic masterEnable,
    output logic discovered,
    output logic dropPulse
);
    import fabric_pkg::*;

    // queue word is one whole packet
    localparam int PW = $bits(pkt_t);

    // ------------------------------------------------------------
    // reset defaults chosen by role
    // ------------------------------------------------------------
    // boot device keeps its id so the boot path survives [R8]
    localparam logic [7:0] BASE_RESET = IS_HOST ? `ID_HOST :
        (IS_BOOT ? `ID_BOOT : `ID_UNASSIGNED); // [R1]
    // a host starts enabled and found
    localparam logic PERMIT_RESET = IS_HOST; // [R2]

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pkt_t head; // oldest queued packet
    logic headValid; // queue not empty
    logic headTake; // head consumed this cycle

    // host-visible registers
    logic [7:0] baseId_q; // base device id register
    logic master_q; // request permission bit
    logic found_q; // found flag
    logic [31:0] hostLock_q; // host id lock
    logic [31:0] compTag_q; // component tag

    // routing table
    logic [7:0] routeSel_q; // routing entry being accessed
    logic [1:0] routeTbl [256]; // id to output port
    logic [255:0] routeSet_q; // entry written since reset

    // egress stage
    logic outValid_q; // egress holding a packet
    pkt_t outPkt_q; // egress packet
    logic drop_q; // one-cycle discard marker

    // ------------------------------------------------------------
    // ingress queue, fed identically from every port
    // ------------------------------------------------------------
    // one shared queue keeps global order
    pkt_fifo #(
        .WIDTH(PW),
        .DEPTH(FIFO_DEPTH)
    ) ingressQ (
        .clk(clk),
        .rst(rst),
        .inData(inPkt),
        .inValid(inValid),
        .inReady(inReady),
        .outData(head),
        .outValid(headValid),
        .outReady(headTake)
    );

    // dropped packets free the head too
    // egress full and not draining stalls the queue (retry/throttle)
    assign headTake = headValid && (!outValid_q || outReady); // [R13]

    // ------------------------------------------------------------
    // decode of the head packet
    // ------------------------------------------------------------
    logic isMaint; // maintenance request
    logic isFinal; // hop count exhausted, this device is target
    logic tooLong; // over the carried size limit
    logic badPkt; // discard instead of handle

    logic [1:0] lookPort; // route lookup result
    logic [31:0] readData; // register read answer

    // same decode whichever port the packet entered on [R25]
    assign isMaint = (head.kind == PK_MREAD) || (head.kind == PK_MWRITE);

    // switches are selected by hop count, end points always [R19]
    assign isFinal = !IS_SWITCH || (head.hop == `HOP_FINAL); // [R3]

    // switches carry whole packets up to the switch limit [R16]
    assign tooLong = IS_SWITCH ? (head.lenBytes > `MAX_SWITCH_PKT) :
        (head.lenBytes > `MAX_PAYLOAD); // [R17]

    // a corrupt packet is dropped alone; the link stays up [R13]
    assign badPkt = head.corrupt || tooLong;

    // unwritten entries keep the default boot and host paths [R8]
    always_comb begin
        if (routeSet_q[head.destId]) begin
            // written entry wins
            lookPort = routeTbl[head.destId]; // [R5]
        end else if (head.destId == `ID_BOOT) begin
            // boot path until rerouted
            lookPort = BOOT_PORT;
        end else if (head.destId == `ID_HOST) begin
            // return path to the host
            lookPort = HOST_PORT;
        end else begin
            // fallback for unknown ids
            lookPort = DEFAULT_PORT;
        end
    end

    // register read mux: capability and control space [R18]
    always_comb begin
        unique case (head.offset)
            // fixed words
            `OFF_DEV_IDENT: readData = DEV_IDENT;
            `OFF_DEV_INFO: readData = DEV_INFO;
            `OFF_ASM_IDENT: readData = ASM_IDENT;
            `OFF_ASM_INFO: readData = ASM_INFO;
            `OFF_PE_FEAT: readData = PE_FEAT;
            // port count and the arrival port [R4]
            `OFF_PORT_INFO: readData = {16'h0000, 8'(PORTS),
                6'h00, head.port};
            // source ops: masters may advertise more [R21] [R22]
            `OFF_SRC_OPS: readData = SRC_OPS;
            // target ops: writes, reads, 34-bit addressing [R20]
            `OFF_DST_OPS: readData = DST_OPS;
            // control space
            `OFF_BASE_ID: readData = {24'h000000, baseId_q}; // [R12]
            `OFF_HOST_LOCK: readData = hostLock_q; // [R11]
            `OFF_COMP_TAG: readData = compTag_q; // [R11]
            `OFF_ROUTE_SEL: readData = {24'h000000, routeSel_q};
            `OFF_ROUTE_PORT: readData = {30'h00000000, lookPortSel()};
            `OFF_PORT_CTL: readData = {master_q, 1'b0, found_q, 29'h0};
            // holes read as zero
            default: readData = `READ_NONE;
        endcase
    end

    // routing entry currently selected for maintenance access
    // keep in step with lookPort
    function automatic logic [1:0] lookPortSel();
        logic [1:0] p;
        p = routeSet_q[routeSel_q] ? routeTbl[routeSel_q] :
            (routeSel_q == `ID_BOOT) ? BOOT_PORT :
            (routeSel_q == `ID_HOST) ? HOST_PORT : DEFAULT_PORT;
        return p;
    endfunction


    // one strobe for all writes
    logic doWrite; // hop-zero maintenance write accepted
    assign doWrite = headTake && !badPkt && isFinal &&
        (head.kind == PK_MWRITE);

    // ------------------------------------------------------------
    // base id and role bits
    // ------------------------------------------------------------
    // host assigns ids and sets the found flag over maintenance [R9]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baseId_q <= BASE_RESET; // [R1]
            master_q <= PERMIT_RESET; // [R2]
            found_q <= PERMIT_RESET; // [R2]
        end else if (doWrite) begin
            // unique id from the host
            if (head.offset == `OFF_BASE_ID) begin
                baseId_q <= head.data[7:0]; // [R12]
            end

            // one word, both role bits
            if (head.offset == `OFF_PORT_CTL) begin
                master_q <= head.data[`CTL_MASTER_EN]; // [R10]
                found_q <= head.data[`CTL_DISCOVERED]; // [R9]
            end
        end
    end

    // ------------------------------------------------------------
    // lock and tag registers
    // ------------------------------------------------------------
    // plain storage, no lock semantics
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hostLock_q <= `LOCK_RESET;
            compTag_q <= `TAG_RESET;
        end else if (doWrite) begin
            if (head.offset == `OFF_HOST_LOCK) begin
                hostLock_q <= head.data; // [R11]
            end

            if (head.offset == `OFF_COMP_TAG) begin
                compTag_q <= head.data; // [R11]
            end
        end
    end

    // ------------------------------------------------------------
    // routing table access
    // ------------------------------------------------------------
    // select register picks the entry the port register touches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            routeSel_q <= 8'h00;
            routeSet_q <= '0;
        end else if (doWrite) begin
            if (head.offset == `OFF_ROUTE_SEL) begin
                routeSel_q <= head.data[7:0]; // [R7]
            end

            // entry now overrides default
            if (head.offset == `OFF_ROUTE_PORT) begin
                routeSet_q[routeSel_q] <= 1'b1; // [R7]
            end
        end
    end

    // table storage; validity comes from routeSet_q
    // no reset: valid bits guard it
    always_ff @(posedge clk) begin
        if (doWrite && head.offset == `OFF_ROUTE_PORT) begin
            routeTbl[routeSel_q] <= head.data[1:0]; // [R7]
        end
    end

    // ------------------------------------------------------------
    // egress: answer, forward or drop, one packet per cycle
    // ------------------------------------------------------------
    // in-order single queue keeps flow-level-one ordering [R14]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outValid_q <= 1'b0;
            outPkt_q <= '0;
            drop_q <= 1'b0;
        end else begin
            // drop leaves only a marker
            drop_q <= headTake && badPkt;

            if (headTake && !badPkt) begin
                outValid_q <= 1'b1;
                if (isMaint && isFinal) begin
                    // answer goes back where the request came in [R23]
                    outPkt_q.kind <= PK_MRESP; // [R3]
                    outPkt_q.hop <= `HOP_RESP;
                    // back to the requester
                    outPkt_q.destId <= head.srcId;
                    outPkt_q.srcId <= baseId_q;
                    outPkt_q.port <= head.port; // [R23]
                    outPkt_q.offset <= head.offset;
                    outPkt_q.data <= (head.kind == PK_MREAD) ?
                        readData : `READ_NONE; // [R3]

                    outPkt_q.lenBytes <= head.lenBytes;
                    outPkt_q.crc <= head.crc;
                    outPkt_q.corrupt <= 1'b0;
                end else begin
                    // forward; check field passes untouched [R15]
                    outPkt_q <= head;
                    outPkt_q.port <= lookPort; // [R6]
                    // only requests carry hops
                    if (isMaint) begin
                        outPkt_q.hop <= head.hop - `HOP_STEP; // [R5]
                    end
                end
            end else if (outReady) begin
                // taken, nothing behind
                outValid_q <= 1'b0;
            end
        end
    end

    // outputs are the registers
    assign outValid = outValid_q;
    assign outPkt = outPkt_q;
    assign baseDeviceId = baseId_q;
    // local requesters must wait for this level [R24] [R10]
    assign masterEnable = master_q;
    assign discovered = found_q;
    assign dropPulse = drop_q;
endmodule
`default_nettype wire

// *** testbench/fabric_discovery_maintenance_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checker: stream handshake, latency, reset state
// ----------------------------------------------------------------
module fabric_discovery_maintenance_properties
    import fabric_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire fabric_pkg::pkt_t inPkt,
    input wire logic inValid,
    input wire logic inReady,
    input wire fabric_pkg::pkt_t outPkt,
    input wire logic outValid,
    input wire logic outReady,
    input wire logic [7:0] baseDeviceId,
    input wire logic masterEnable,
    input wire logic discovered,
    input wire logic dropPulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [4:0] inFlight_q; // taken, not yet delivered or dropped
    logic fresh; // packet taken into an idle block, never dropped
    assign fresh = inValid && inReady && inFlight_q == 5'd0
        && !inPkt.corrupt && inPkt.lenBytes <= 9'd256;
    // drops are counted late, so the count only errs high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inFlight_q <= 5'd0;
        end else begin
            inFlight_q <= inFlight_q + 5'(inValid && inReady)
                - 5'(outValid && outReady) - 5'(dropPulse);
        end
    end
    a_reset_ids: assert property ($fell(rst) |->
        baseDeviceId == 8'hff && !masterEnable && !discovered)
        else $error("identity not at reset value");
    a_reset_stream: assert property ($fell(rst) |->
        inReady && !outValid && !dropPulse)
        else $error("stream not idle after reset");
    a_out_hold: assert property (outValid && !outReady |=>
        outValid && $stable(outPkt)) else $error("egress not held");
    a_full_backed: assert property (!inReady |-> inFlight_q >= 5'd8)
        else $error("refused with room left");
    a_out_backed: assert property (outValid |-> inFlight_q != 5'd0)
        else $error("egress without a packet");
    a_flight_max: assert property (inFlight_q <= 5'd10)
        else $error("more packets held than space");
    a_regs_quiet: assert property ($changed({baseDeviceId, masterEnable,
        discovered}) |-> inFlight_q != 5'd0)
        else $error("control bits moved with no write");
    a_empty_answer: assert property (fresh |-> ##2 outValid)
        else $error("idle answer late");
    a_hop0_reply: assert property (fresh && inPkt.hop == 8'h00 &&
        inPkt.kind inside {PK_MREAD, PK_MWRITE} |-> ##2
        outPkt.kind == PK_MRESP && outPkt.port == $past(inPkt.port, 2))
        else $error("reply not on arrival port");
    a_hop_decrement: assert property (fresh && inPkt.hop != 8'h00 &&
        inPkt.kind inside {PK_MREAD, PK_MWRITE} |-> ##2
        outPkt.hop == $past(inPkt.hop, 2) - 8'h01)
        else $error("hop count not decremented");
    c_full: cover property (!inReady);
    c_drop: cover property (dropPulse);
    c_read: cover property (fresh && inPkt.kind == PK_MREAD);
endmodule
bind fabric_discovery_maintenance fabric_discovery_maintenance_properties
    i_fabric_discovery_maintenance_properties (.clk(clk), .rst(rst),
    .inPkt(inPkt), .inValid(inValid), .inReady(inReady),
    .outPkt(outPkt), .outValid(outValid), .outReady(outReady),
    .baseDeviceId(baseDeviceId), .masterEnable(masterEnable),
    .discovered(discovered), .dropPulse(dropPulse));
`default_nettype wire

// *** testbench/host_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host side sink: takes egress packets, stalls on request
// ----------------------------------------------------------------
module host_sink
    import fabric_pkg::*;
(
    input wire logic clk,
    input wire logic stall,
    input wire fabric_pkg::pkt_t outPkt,
    input wire logic outValid,
    output logic outReady
);
    pkt_t got[$]; // packets seen, oldest first
    assign outReady = !stall;
    // capture only at the accepting edge, never early
    always @(posedge clk) begin
        if (outValid && outReady) begin
            got.push_back(outPkt);
        end
    end
endmodule
`default_nettype wire

// *** testbench/fabric_discovery_maintenance_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bench: host side maintenance traffic
// ----------------------------------------------------------------
module fabric_discovery_maintenance_test
    import fabric_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pkt_t inPkt = '0;
    logic inValid = 1'b0;
    logic stall = 1'b0;
    logic inReady, outValid, outReady, masterEnable, discovered, dropPulse;
    pkt_t outPkt;
    logic [7:0] baseDeviceId;
    int numErrors = 0;
    int testsRun = 0;
    int drops = 0;
    int cycles = 0;
    pkt_t r;
    fabric_discovery_maintenance i_fabric_discovery_maintenance (
        .clk(clk), .rst(rst), .inPkt(inPkt), .inValid(inValid),
        .inReady(inReady), .outPkt(outPkt), .outValid(outValid),
        .outReady(outReady), .baseDeviceId(baseDeviceId),
        .masterEnable(masterEnable), .discovered(discovered),
        .dropPulse(dropPulse));
    host_sink i_host_sink (.clk(clk), .stall(stall), .outPkt(outPkt),
        .outValid(outValid), .outReady(outReady));
    always #20 clk = ~clk;
    // watchdog and drop counter
    always @(posedge clk) begin
        cycles++;
        drops += int'(dropPulse);
        if (cycles == 20000) begin
            numErrors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        testsRun++;
        if (g !== e) begin
            numErrors++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    function automatic pkt_t mk(pkt_kind_t k, logic [7:0] h, logic [7:0] d,
        logic [1:0] pt, logic [23:0] o, logic [31:0] v);
        return '{kind:k, hop:h, destId:d, srcId:8'h00, port:pt, offset:o,
            data:v, lenBytes:9'h010, crc:16'hbeef, corrupt:1'b0};
    endfunction
    // hold the request until the edge that takes it
    task automatic send(input pkt_t p);
        inPkt = p;
        inValid = 1'b1;
        while (!inReady) @(negedge clk);
        @(negedge clk);
    endtask
    task automatic xfer(input pkt_t p, output pkt_t q);
        int n;
        send(p);
        inValid = 1'b0;
        for (n = 0; n < 50 && i_host_sink.got.size() == 0; n++) begin
            @(negedge clk);
        end
        q = (n < 50) ? i_host_sink.got.pop_front() : '0;
        chk(n < 50, 1);
    endtask
    task automatic rd(input logic [23:0] o, input logic [1:0] pt);
        xfer(mk(PK_MREAD, 8'h00, 8'hff, pt, o, 32'h0), r);
    endtask
    task automatic wr(input logic [23:0] o, input logic [31:0] v);
        xfer(mk(PK_MWRITE, 8'h00, 8'hff, 2'h2, o, v), r);
    endtask
    task automatic fwd(input pkt_kind_t k, input logic [7:0] h,
        input logic [7:0] d, input logic [1:0] ep, input logic [7:0] eh);
        xfer(mk(k, h, d, 2'h2, 24'h0, 32'h0), r);
        chk({r.kind, r.port, r.hop, r.destId}, {k, ep, eh, d});
        chk(r.crc, 16'hbeef);
    endtask
    task automatic t_reset();
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(baseDeviceId, 8'hff);
        chk({masterEnable, discovered}, 2'b00);
        chk({inReady, outValid, dropPulse}, 3'b100);
        $display("test reset done");
    endtask
    task automatic t_caps();
        logic [23:0] o[7] = '{24'h0, 24'h4, 24'h8, 24'hc, 24'h10, 24'h18,
            24'h1c};
        logic [31:0] v[7] = '{32'h12345678, 32'h1, 32'habcd, 32'h100,
            32'h10000001, 32'h0, 32'hc0};
        for (int i = 0; i < 7; i++) begin
            rd(o[i], 2'h2);
            chk(r.data, v[i]);
        end
        for (int p = 0; p < 4; p++) begin
            rd(24'h14, 2'(p));
            chk(r.data, {16'h0000, 8'h04, 6'h00, 2'(p)});
            chk({r.kind, r.port, r.hop}, {PK_MRESP, 2'(p), 8'hff});
        end
        $display("test capability reads done");
    endtask
    task automatic t_route();
        fwd(PK_MREAD, 8'h01, 8'hff, 2'h0, 8'h00);
        fwd(PK_MREAD, 8'h01, 8'hfe, 2'h1, 8'h00);
        fwd(PK_MRESP, 8'hff, 8'h00, 2'h2, 8'hff);
        wr(24'h70, 32'hff);
        wr(24'h74, 32'h3);
        fwd(PK_MWRITE, 8'h02, 8'hff, 2'h3, 8'h01);
        rd(24'h74, 2'h2);
        chk(r.data[1:0], 2'h3);
        $display("test routing done");
    endtask
    task automatic t_ctl();
        wr(24'h13c, 32'h20000000);
        chk({masterEnable, discovered}, 2'b01);
        wr(24'h60, 32'h1);
        chk(baseDeviceId, 8'h01);
        wr(24'h13c, 32'ha0000000);
        chk({masterEnable, discovered}, 2'b11);
        rd(24'h68, 2'h2);
        chk(r.data, 32'h0000ffff);
        rd(24'h6c, 2'h2);
        chk(r.data, 32'h0);
        wr(24'h68, 32'h12);
        wr(24'h6c, 32'h5a);
        rd(24'h68, 2'h2);
        chk(r.data, 32'h12);
        rd(24'h6c, 2'h2);
        chk(r.data, 32'h5a);
        rd(24'h200, 2'h2);
        chk(r.data, 32'h0);
        $display("test control registers done");
    endtask
    task automatic t_drop();
        pkt_t p;
        int d0;
        for (int i = 0; i < 2; i++) begin
            p = mk(PK_OTHER, 8'h01, 8'h05, 2'h2, 24'h0, 32'h0);
            p.corrupt = (i == 0);
            p.lenBytes = (i == 0) ? 9'h010 : 9'h115;
            d0 = drops;
            send(p);
            inValid = 1'b0;
            repeat (12) @(negedge clk);
            chk(drops - d0, 1);
            chk(i_host_sink.got.size(), 0);
        end
        p.lenBytes = 9'h114;
        xfer(p, r);
        chk(r.lenBytes, 9'h114);
        $display("test drops done");
    endtask
    task automatic t_fifo();
        pkt_t p;
        int n;
        stall = 1'b1;
        inValid = 1'b1;
        for (n = 0; n < 12; n++) begin
            p = mk(PK_OTHER, 8'h01, 8'h05, 2'h2, 24'h0, 32'h0);
            p.srcId = 8'(n);
            inPkt = p;
            if (!inReady) break;
            @(negedge clk);
        end
        inValid = 1'b0;
        chk(n >= 8 && n <= 9, 1);
        for (int i = 0; i < 200 && i_host_sink.got.size() < n; i++) begin
            stall = i[0];
            @(negedge clk);
        end
        stall = 1'b0;
        chk(i_host_sink.got.size(), n);
        for (int i = 0; i < n; i++) begin
            r = i_host_sink.got.pop_front();
            chk(r.srcId, 8'(i));
        end
        $display("test queue full and drain done");
    endtask
    initial begin
        @(negedge clk);
        t_reset();
        t_caps();
        t_route();
        t_ctl();
        t_drop();
        t_fifo();
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
